// ---- design/cmpc_defs.vh ----
// constants for the comparator reference control block
`ifndef CMPC_DEFS_VH
`define CMPC_DEFS_VH
// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define CMPC_OFF_CTRL       12'h0f90
`define CMPC_OFF_STATUS     12'h0f94
`define CMPC_OFF_IRQ_STAT   12'h0f98
`define CMPC_OFF_IRQ_MASK   12'h0f9c
`define CMPC_OFF_POWER      12'h0fa0
// -----------------------------------------------------------------
// control fields and reset values
// -----------------------------------------------------------------
`define CMPC_SEL_BIT        6
`define CMPC_LVL_HI         5
`define CMPC_LVL_LO         2
`define CMPC_CTRL_RESET     8'h14
`define CMPC_LVL_MAX        4'h9
`define CMPC_LVL_DEFAULT    4'h5
`define CMPC_LVL_STEP_MV    200
// -----------------------------------------------------------------
// interrupt status bits
// -----------------------------------------------------------------
`define CMPC_IRQ_RISE       0
`define CMPC_IRQ_FALL       1
`define CMPC_IRQ_RESET      2'h0
`define CMPC_POWER_RESET    1'b0
// -----------------------------------------------------------------
// axi responses
// -----------------------------------------------------------------
`define CMPC_RESP_OKAY      2'h0
`define CMPC_RESP_SLVERR    2'h2
`endif

// ---- design/cmpc_sync.v ----
// three-stage synchroniser for the analog comparator result
`timescale 1ns/10ps
module cmpc_sync (
  aclk,
  aresetn,
  async_in,
  sync_out,
  sync_valid
);
  input  wire aclk;
  input  wire aresetn;
  input  wire async_in;
  output reg  sync_out;
  output wire sync_valid;

  reg stage1;
  reg stage2;
  reg stage3;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= 1'b0;
      stage2   <= 1'b0;
      stage3   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end

  assign sync_valid = (stage2 == stage3);
endmodule

// ---- design/cmpc_top.v ----
// comparator reference control with axi4-lite register slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "cmpc_defs.vh"
module cmpc_top (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awprot,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arprot,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  comparator_raw,
  positive_select_pin,
  negative_source_select,
  reference_level,
  reference_enable,
  comparator_power_down,
  comparator_pin_out,
  irq
);
  input  wire        aclk;
  input  wire        aresetn;
  input  wire [11:0] s_axi_awaddr;
  input  wire [2:0]  s_axi_awprot;
  input  wire        s_axi_awvalid;
  output reg         s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output reg         s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [11:0] s_axi_araddr;
  input  wire [2:0]  s_axi_arprot;
  input  wire        s_axi_arvalid;
  output reg         s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  input  wire        comparator_raw;
  output reg         positive_select_pin;
  output reg         negative_source_select;
  output reg  [3:0]  reference_level;
  output reg         reference_enable;
  output reg         comparator_power_down;
  output reg         comparator_pin_out;
  output reg         irq;

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  reg  [7:0]  comparator_control;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg         power_down;
  reg         prev_result;
  reg  [11:0] wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         have_aw;
  reg         have_w;
  wire        result_sync;
  wire        result_stable;
  wire [1:0]  events;
  wire [1:0]  next_irq_status;
  reg  [1:0]  next_irq_mask;
  wire        wr_low;
  wire        hit_ctrl;
  wire        hit_irq_stat;
  wire        hit_irq_mask;
  wire        hit_power;
  genvar      gi;
  reg  [31:0] read_word;
  reg         read_ok;
  wire        do_write;

  // -----------------------------------------------------------------
  // decoding helper
  // -----------------------------------------------------------------
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `CMPC_OFF_CTRL) ||
                  (addr == `CMPC_OFF_STATUS) ||
                  (addr == `CMPC_OFF_IRQ_STAT) ||
                  (addr == `CMPC_OFF_IRQ_MASK) ||
                  (addr == `CMPC_OFF_POWER);
    end
  endfunction

  // low-byte write landing on one register
  function write_hit;
    input        strobe;
    input [11:0] waddr;
    input [11:0] target;
    begin
      write_hit = strobe && (waddr == target);
    end
  endfunction

  // -----------------------------------------------------------------
  // comparator result path
  // -----------------------------------------------------------------
  cmpc_sync u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .async_in   (comparator_raw),
    .sync_out   (result_sync),
    .sync_valid (result_stable)
  );

  // -----------------------------------------------------------------
  // interrupt events
  // -----------------------------------------------------------------
  // powered-down comparator produces no events
  assign events[`CMPC_IRQ_RISE] = result_sync & ~prev_result & ~power_down;
  assign events[`CMPC_IRQ_FALL] = ~result_sync & prev_result & ~power_down;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_result <= 1'b0;
    end else begin
      prev_result <= result_sync;
    end
  end

  // -----------------------------------------------------------------
  // axi write channel
  // -----------------------------------------------------------------
  // readies stay low until the response is taken
  assign do_write = have_aw & have_w & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      wr_addr       <= 12'h0000;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CMPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        have_aw       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        have_w       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_addr) ? `CMPC_RESP_OKAY :
                        `CMPC_RESP_SLVERR;
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // write decode
  // -----------------------------------------------------------------
  assign wr_low       = do_write & wr_strb[0];
  assign hit_ctrl     = write_hit(wr_low, wr_addr, `CMPC_OFF_CTRL);
  assign hit_irq_stat = write_hit(wr_low, wr_addr, `CMPC_OFF_IRQ_STAT);
  assign hit_irq_mask = write_hit(wr_low, wr_addr, `CMPC_OFF_IRQ_MASK);
  assign hit_power    = write_hit(wr_low, wr_addr, `CMPC_OFF_POWER);

  // -----------------------------------------------------------------
  // interrupt status and mask
  // -----------------------------------------------------------------
  // one sticky bit per event; a new event wins over a clear
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_status
      assign next_irq_status[gi] = events[gi] |
        (irq_status[gi] & ~(hit_irq_stat & wr_data[gi]));
    end
  endgenerate

  // irq follows a mask write at the same edge as the register
  always @* begin
    next_irq_mask = irq_mask;
    if (hit_irq_mask) begin
      next_irq_mask = wr_data[1:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `CMPC_IRQ_RESET;
      irq_mask   <= `CMPC_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  // -----------------------------------------------------------------
  // control and power registers
  // -----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_control <= `CMPC_CTRL_RESET;
      power_down         <= `CMPC_POWER_RESET;
    end else begin
      if (hit_ctrl) begin
        // reserved bits stored as written by software
        comparator_control <= wr_data[7:0];
      end
      if (hit_power) begin
        power_down <= wr_data[0];
      end
    end
  end

  // -----------------------------------------------------------------
  // axi read channel
  // -----------------------------------------------------------------
  // read word decoded from the address on offer
  always @* begin
    read_word = 32'h0000_0000;
    read_ok   = 1'b1;
    case (s_axi_araddr)
      `CMPC_OFF_CTRL: begin
        read_word[7:0] = comparator_control;
      end
      `CMPC_OFF_STATUS: begin
        read_word[0] = result_sync;
        read_word[1] = result_stable;
      end
      `CMPC_OFF_IRQ_STAT: begin
        read_word[1:0] = irq_status;
      end
      `CMPC_OFF_IRQ_MASK: begin
        read_word[1:0] = irq_mask;
      end
      `CMPC_OFF_POWER: begin
        read_word[0] = power_down;
      end
      default: begin
        read_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CMPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word;
        s_axi_rresp   <= read_ok ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // analog control outputs
  // -----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      positive_select_pin    <= 1'b1;
      negative_source_select <= 1'b0;
      reference_level        <= `CMPC_LVL_DEFAULT;
      reference_enable       <= 1'b0;
      comparator_power_down  <= `CMPC_POWER_RESET;
    end else begin
      // positive input tied to its pin in every setting
      positive_select_pin    <= 1'b1;
      negative_source_select <= comparator_control[`CMPC_SEL_BIT];
      // own field only; no link to converter reference
      reference_level        <=
        comparator_control[`CMPC_LVL_HI:`CMPC_LVL_LO];
      reference_enable       <= comparator_control[`CMPC_SEL_BIT] &
                                ~power_down;
      comparator_power_down  <= power_down;
    end
  end

  // -----------------------------------------------------------------
  // result pin and interrupt line
  // -----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_pin_out <= 1'b0;
      irq                <= 1'b0;
    end else begin
      comparator_pin_out <= result_sync & ~power_down;
      irq                <= |(next_irq_status & next_irq_mask);
    end
  end
endmodule

// ---- dv/cmpc_analog_model.sv ----
// behavioural analog comparator seen from the pins
`timescale 1ns/10ps
module cmpc_analog_model (
  input  wire drive,
  output reg  comparator_raw
);
  initial comparator_raw = 1'b0;
  // prompt or slow settling, async to the clock
  always @(drive)
    comparator_raw <= #($urandom % 60) drive;
endmodule

// ---- dv/cmpc_top_sva.sv ----
// assertions on the ports of the comparator control block
`timescale 1ns/10ps
`include "cmpc_defs.vh"
module cmpc_top_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        comparator_raw,
  input wire        positive_select_pin,
  input wire        negative_source_select,
  input wire [3:0]  reference_level,
  input wire        reference_enable,
  input wire        comparator_power_down,
  input wire        comparator_pin_out,
  input wire        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_answer;
    s_axi_rvalid;
  endsequence
  a_pos_pin: assert property (positive_select_pin)
    else $error("positive input left its pin");
  a_ref_enable: assert property (reference_enable ==
    (negative_source_select && !comparator_power_down))
    else $error("reference enable wrong");
  a_reset_vals: assert property (disable iff (1'b0)
    !aresetn |=> reference_level == `CMPC_LVL_DEFAULT
    && !negative_source_select)
    else $error("reset values wrong");
  a_pd_pin: assert property (comparator_power_down [*2]
    |-> !comparator_pin_out)
    else $error("pin out while powered down");
  a_sync_lag: assert property ($rose(comparator_pin_out)
    |-> $past(comparator_raw, 2))
    else $error("result not synchronised");
  a_irq_clear: assert property ($fell(irq)
    |-> $rose(s_axi_bvalid))
    else $error("irq fell without a write");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_latency: assert property (ar_taken |=> r_answer)
    else $error("read answer late");
endmodule
bind cmpc_top cmpc_top_sva cmpc_top_sva_inst (.*);

// ---- dv/cmpc_top_tb_top.sv ----
// self-checking bench for the comparator control block
`timescale 1ns/10ps
`include "cmpc_defs.vh"
module cmpc_top_tb_top;
  reg         aclk, aresetn, drive;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [2:0]  s_axi_awprot, s_axi_arprot;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, sel;
  reg  [31:0] s_axi_wdata, lastv;
  reg  [3:0]  s_axi_wstrb;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid, comparator_raw;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        positive_select_pin, negative_source_select;
  wire        reference_enable, comparator_power_down;
  wire        comparator_pin_out, irq;
  wire [3:0]  reference_level;
  reg  [33:0] q[$];
  integer     fails, cmp_count, cyc, i, n;

  cmpc_top cmpc_top_inst (.*);
  cmpc_analog_model cmpc_analog_model_inst (
    .drive          (drive),
    .comparator_raw (comparator_raw)
  );

  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // ----------------------------------------
  // compare, close and bus tasks
  // ----------------------------------------
  task automatic chk(input [33:0] s, input [33:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task automatic wr(input [11:0] a, input [31:0] d, input [3:0] st,
                    input [1:0] r);
    reg ta, tw;
    begin
      q.push_back({r, 32'h0000_0000});
      ta = 0;
      tw = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ta && tw)) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) begin
          ta = 1;
          s_axi_awvalid <= 0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          tw = 1;
          s_axi_wvalid <= 0;
        end
      end
      repeat ($urandom % 3) @(posedge aclk);
      s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] d, input [1:0] r);
    begin
      q.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      repeat ($urandom % 3) @(posedge aclk);
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
    end
  endtask
  task edge_evt(input v, input [1:0] st);
    begin
      drive <= v;
      n = 0;
      while (comparator_pin_out !== v && n < 20) begin
        @(posedge aclk);
        n = n + 1;
      end
      chk(comparator_pin_out, v);
      @(posedge aclk);
      chk(irq, 1);
      rd(`CMPC_OFF_STATUS, {1'b1, v}, 0);
      rd(`CMPC_OFF_IRQ_STAT, st, 0);
      wr(`CMPC_OFF_IRQ_STAT, st, 4'hf, 0);
      chk(irq, 0);
    end
  endtask
  // ----------------------------------------
  // result monitor and hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0000_0000}, q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      finish_test;
    end
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_wdata, s_axi_wstrb} = 0;
    {aresetn, drive, fails, cmp_count, cyc} = 0;
    n = $urandom(51);
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    chk(positive_select_pin, 1);
    chk(reference_level, `CMPC_LVL_DEFAULT);
    chk(negative_source_select, 0);
    rd(`CMPC_OFF_CTRL, `CMPC_CTRL_RESET, 0);
    $display("reset test done");
    for (i = 0; i < 10; i = i + 1) begin
      sel = $urandom;
      lastv = {sel, i[3:0], 2'b00};
      wr(`CMPC_OFF_CTRL, lastv, 4'hf, 0);
      rd(`CMPC_OFF_CTRL, lastv, 0);
      chk(reference_level, i[3:0]);
      chk(negative_source_select, sel);
      chk(reference_enable, sel);
    end
    wr(`CMPC_OFF_CTRL, 32'h0000_0000, 4'h0, 0);
    rd(`CMPC_OFF_CTRL, lastv, 0);
    wr(12'h0ffc, 32'h0000_0001, 4'hf, `CMPC_RESP_SLVERR);
    rd(12'h0ffc, 32'h0000_0000, `CMPC_RESP_SLVERR);
    $display("register test done");
    wr(`CMPC_OFF_IRQ_MASK, 0, 4'hf, 0);
    wr(`CMPC_OFF_CTRL, 32'h0000_0054, 4'hf, 0);
    repeat (2) @(posedge aclk);
    wr(`CMPC_OFF_IRQ_STAT, 3, 4'hf, 0);
    wr(`CMPC_OFF_IRQ_MASK, 3, 4'hf, 0);
    rd(`CMPC_OFF_IRQ_MASK, 3, 0);
    edge_evt(1, 1);
    edge_evt(0, 2);
    $display("event test done");
    wr(`CMPC_OFF_POWER, 1, 4'hf, 0);
    @(posedge aclk);
    chk(comparator_power_down, 1);
    chk(reference_enable, 0);
    rd(`CMPC_OFF_POWER, 1, 0);
    drive <= 1;
    repeat (12) @(posedge aclk);
    chk(comparator_pin_out, 0);
    chk(irq, 0);
    $display("power test done");
    finish_test;
  end
endmodule
